// File: design/dswp_port.sv
// Serial write port: 24-bit falling-edge shifter that loads an 18-bit converter code
`timescale 1ns/1ps
// What this block does
// - Low frame select enables the shift register
// - Sample data on each serial clock fall, up to the 24th of a frame
// - Shift register is 24 bits wide
// - Load code on the 24th falling edge
// - Early frame select rise aborts, no load
// - Code is 18-bit straight binary
// - Frame: 2 ignored, 2 reserved, 18 code, 2 ignored
// - Abort clears shifter, nothing else changes
// - Power-on code zero or midscale until load
module dswp_port #(
  parameter bit MIDSCALE_RESET = 1'b0
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire dswp_pkg::dswp_pins_s        pins,
  output      dswp_pkg::dswp_out_s         dac
);
  import dswp_pkg::*;

  // Power-on code depends on the variant; it holds until the first complete frame
  localparam logic [CODE_BITS-1:0] RST_CODE = MIDSCALE_RESET ? CODE_MID : CODE_ZERO;

  // ==========================================
  // Frame field decoding
  // One place for the field positions, shared by the load path and its checks
  function automatic logic [CODE_BITS-1:0] code_of(input logic [FRAME_BITS-1:0] word);
    return word[CODE_LSB +: CODE_BITS];
  endfunction

  // Reserved bits still let the code load; this only reports them
  function automatic logic rsvd_of(input logic [FRAME_BITS-1:0] word);
    return |word[RSVD_LSB +: RSVD_BITS];
  endfunction

  // ==========================================
  // Pin synchronisers
  logic [1:0] sync_fr_ff, nxt_sync_fr;
  logic [1:0] sync_ck_ff, nxt_sync_ck;
  logic [1:0] sync_dt_ff, nxt_sync_dt;
  logic       ck_d_ff,    nxt_ck_d;

  always_comb begin
    nxt_sync_fr = {sync_fr_ff[0], pins.frame_n};
    nxt_sync_ck = {sync_ck_ff[0], pins.sclk};
    nxt_sync_dt = {sync_dt_ff[0], pins.sdata};
    nxt_ck_d    = sync_ck_ff[1];
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_fr_ff <= SYNC_RST;
      sync_ck_ff <= CLK_RST;
      sync_dt_ff <= DAT_RST;
      ck_d_ff    <= 1'b0;
    end else begin
      sync_fr_ff <= nxt_sync_fr;
      sync_ck_ff <= nxt_sync_ck;
      sync_dt_ff <= nxt_sync_dt;
      ck_d_ff    <= nxt_ck_d;
    end
  end

  logic frame_lo;
  logic ck_fall;
  assign frame_lo = ~sync_fr_ff[1];
  // Both pins take the same sync delay, so data is seen as it stood at the fall
  assign ck_fall  = ck_d_ff & ~sync_ck_ff[1];

  // ==========================================
  // Frame shifter and converter register
  logic [FRAME_BITS-1:0] shift_ff, nxt_shift;
  logic [CNT_BITS-1:0]   cnt_ff,   nxt_cnt;
  logic                  armed_ff, nxt_armed;
  logic                  fr_d_ff,  nxt_fr_d;
  dswp_out_s             dac_ff,   nxt_dac;
  logic [FRAME_BITS-1:0] full_word;

  assign full_word = {shift_ff[FRAME_BITS-2:0], sync_dt_ff[1]};

  always_comb begin
    nxt_shift      = shift_ff;
    nxt_cnt        = cnt_ff;
    nxt_armed      = armed_ff;
    nxt_fr_d       = frame_lo;
    nxt_dac        = dac_ff;
    nxt_dac.update = 1'b0;
    nxt_dac.abort  = 1'b0;
    if (!frame_lo) begin
      nxt_cnt   = CNT_ZERO;
      nxt_shift = SHIFT_RST;
      nxt_armed = 1'b1;
      nxt_dac.abort = fr_d_ff & armed_ff & (cnt_ff != CNT_ZERO);
    end else if (ck_fall && armed_ff) begin
      nxt_shift = full_word;
      nxt_cnt   = cnt_ff + CNT_ONE;
      if (cnt_ff == CNT_LAST) begin
        // Further edges are ignored until frame select rises again
        nxt_armed        = 1'b0;
        nxt_dac.code     = code_of(full_word);
        nxt_dac.rsvd_nonzero = rsvd_of(full_word);
        nxt_dac.update   = 1'b1;
        nxt_cnt          = CNT_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      shift_ff <= SHIFT_RST;
      cnt_ff   <= CNT_ZERO;
      armed_ff <= 1'b0;
      fr_d_ff  <= 1'b0;
      dac_ff   <= '0;
      dac_ff.code <= RST_CODE;
    end else begin
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
      armed_ff <= nxt_armed;
      fr_d_ff  <= nxt_fr_d;
      dac_ff   <= nxt_dac;
    end
  end

  assign dac = dac_ff;

  // ==========================================
  // Checks
  property p_hold_code;
    @(posedge core_clk) disable iff (reset) !dac_ff.update |=> $stable(dac_ff.code) || dac_ff.update;
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("code changed without update");

  property p_update_cnt;
    @(posedge core_clk) disable iff (reset) (frame_lo && ck_fall && armed_ff && cnt_ff == CNT_LAST) |=> dac_ff.update;
  endproperty
  a_update_cnt: assert property (p_update_cnt) else $error("no update on 24th edge");

  property p_update_frame;
    @(posedge core_clk) disable iff (reset) dac_ff.update |-> $past(frame_lo) && $past(cnt_ff) == CNT_LAST;
  endproperty
  a_update_frame: assert property (p_update_frame) else $error("update outside full frame");

  property p_code_value;
    @(posedge core_clk) disable iff (reset) dac_ff.update |-> dac_ff.code == $past(code_of(full_word));
  endproperty
  a_code_value: assert property (p_code_value) else $error("wrong code loaded");

  property p_idle_clear;
    @(posedge core_clk) disable iff (reset) !frame_lo |=> cnt_ff == CNT_ZERO && shift_ff == SHIFT_RST;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("shifter not cleared");

  property p_shift_in;
    @(posedge core_clk) disable iff (reset) (frame_lo && ck_fall && armed_ff) |=> shift_ff[0] == $past(sync_dt_ff[1]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not sampled");

  property p_no_rearm;
    @(posedge core_clk) disable iff (reset) dac_ff.update |-> !armed_ff;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("armed after load");

  property p_abort_no_update;
    @(posedge core_clk) disable iff (reset) dac_ff.abort |-> !dac_ff.update ##1 !dac_ff.update;
  endproperty
  a_abort_no_update: assert property (p_abort_no_update) else $error("update on abort");

  property p_abort_cnt;
    @(posedge core_clk) disable iff (reset)
      (!frame_lo && fr_d_ff && armed_ff && cnt_ff != CNT_ZERO) |=> dac_ff.abort;
  endproperty
  a_abort_cnt: assert property (p_abort_cnt) else $error("no abort on early frame end");

  property p_abort_code;
    @(posedge core_clk) disable iff (reset) dac_ff.abort |-> $stable(dac_ff.code) && $stable(dac_ff.rsvd_nonzero);
  endproperty
  a_abort_code: assert property (p_abort_code) else $error("code moved on abort");

  property p_abort_clear;
    @(posedge core_clk) disable iff (reset) dac_ff.abort |-> cnt_ff == CNT_ZERO && shift_ff == SHIFT_RST;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("partial frame kept");

  property p_cnt_step;
    @(posedge core_clk) disable iff (reset)
      (frame_lo && ck_fall && armed_ff && cnt_ff != CNT_LAST) |=> cnt_ff == $past(cnt_ff) + CNT_ONE;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("edge not counted");

  property p_cnt_hold;
    @(posedge core_clk) disable iff (reset) (frame_lo && !ck_fall) |=> $stable(cnt_ff);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("count moved without edge");

  property p_cnt_range;
    @(posedge core_clk) disable iff (reset) cnt_ff <= CNT_LAST;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count past frame length");

  property p_upd_pulse;
    @(posedge core_clk) disable iff (reset) dac_ff.update |=> !dac_ff.update;
  endproperty
  a_upd_pulse: assert property (p_upd_pulse) else $error("update longer than one cycle");

  property p_rsvd_keep;
    @(posedge core_clk) disable iff (reset) !dac_ff.update |=> $stable(dac_ff.rsvd_nonzero) || dac_ff.update;
  endproperty
  a_rsvd_keep: assert property (p_rsvd_keep) else $error("reserved flag changed without update");

  // Sampled reset in the antecedent: the disable sees the release one edge before the flops do
  property p_armed_idle;
    @(posedge core_clk) disable iff (reset) (!reset && !frame_lo) |=> armed_ff;
  endproperty
  a_armed_idle: assert property (p_armed_idle) else $error("not armed while frame select high");

  property p_ignore_extra;
    @(posedge core_clk) disable iff (reset)
      (frame_lo && ck_fall && !armed_ff) |=> $stable(shift_ff) && $stable(cnt_ff) && !dac_ff.update;
  endproperty
  a_ignore_extra: assert property (p_ignore_extra) else $error("edge taken after complete frame");

  // No disable here: this one looks at the first edge after reset is let go
  property p_reset_code;
    @(posedge core_clk) $fell(reset) |->
      dac_ff.code == RST_CODE && !dac_ff.rsvd_nonzero && !dac_ff.update && !dac_ff.abort;
  endproperty
  a_reset_code: assert property (p_reset_code) else $error("wrong code after reset");

  c_update: cover property (@(posedge core_clk) disable iff (reset) dac_ff.update);
  c_abort: cover property (@(posedge core_clk) disable iff (reset) dac_ff.abort);
  c_full: cover property (@(posedge core_clk) disable iff (reset) dac_ff.update && dac_ff.code == CODE_FULL);
  c_ignored: cover property (@(posedge core_clk) disable iff (reset) frame_lo && ck_fall && !armed_ff);
  c_reset_code: cover property (@(posedge core_clk) $fell(reset));
endmodule

// File: common/dswp_pkg.sv
// Package for the serial write port of the converter: widths, frame layout, reset codes
package dswp_pkg;
  localparam int FRAME_BITS   = 24;
  localparam int CODE_BITS    = 18;
  localparam int CNT_BITS     = 5;
  localparam int CODE_LSB     = 2;
  localparam int RSVD_LSB     = 20;
  localparam int RSVD_BITS    = 2;
  localparam logic [CNT_BITS-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [CNT_BITS-1:0]  CNT_ONE   = 5'h01;
  localparam logic [CNT_BITS-1:0]  CNT_LAST  = 5'h17;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 24'h000000;
  localparam logic [CODE_BITS-1:0] CODE_ZERO = 18'h00000;
  localparam logic [CODE_BITS-1:0] CODE_MID  = 18'h20000;
  localparam logic [CODE_BITS-1:0] CODE_FULL = 18'h3FFFF;
  localparam logic [1:0]           SYNC_RST  = 2'h3;
  localparam logic [1:0]           CLK_RST   = 2'h0;
  localparam logic [1:0]           DAT_RST   = 2'h0;

  typedef struct packed {
    logic frame_n;
    logic sclk;
    logic sdata;
  } dswp_pins_s;

  typedef struct packed {
    logic [CODE_BITS-1:0] code;
    logic                 rsvd_nonzero;
    logic                 update;
    logic                 abort;
  } dswp_out_s;
endpackage

// File: dv/dswp_host.sv
// Host model that drives the three-wire write port
`timescale 1ns/1ps
module dswp_host (
  output dswp_pkg::dswp_pins_s pins
);
  import dswp_pkg::*;
  initial pins = '{frame_n: 1'b1, sclk: 1'b0, sdata: 1'b0};
  // ===========================================
  // Frame driver
  // Serial clock only toggles inside a frame, 125 ns period
  // Non-blocking, so a pin change that lands on a core clock edge does not race the sampler
  task automatic frame(input logic [23:0] w, input int n);
    pins.frame_n <= 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      pins.sdata <= w[(47 - i) % 24];
      pins.sclk  <= 1'b1;
      #62.5 pins.sclk <= 1'b0;
      #62.5;
    end
    pins.frame_n <= 1'b1;
    // Released data line must not look like the last bit
    pins.sdata   <= ~pins.sdata;
    #200;
  endtask
endmodule

// File: dv/dswp_port_bench.sv
// Testbench for the serial write port
`timescale 1ns/1ps
module dswp_port_bench;
  import dswp_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  dswp_pins_s pins;
  dswp_out_s  dac;
  dswp_out_s  dac_mid;
  int         failures = 0;
  int         n_tests  = 0;
  int         n_upd    = 0;
  int         n_abt    = 0;
  always #4 core_clk = ~core_clk;
  dswp_port uut (.core_clk(core_clk), .reset(reset), .pins(pins), .dac(dac));
  // Midscale variant shares the pins so its power-on code is checked too
  dswp_port #(.MIDSCALE_RESET(1'b1)) uut_mid (.core_clk(core_clk), .reset(reset), .pins(pins), .dac(dac_mid));
  dswp_host host (.pins(pins));
  // ===========================================
  // Pulse counters
  always @(posedge core_clk) begin
    if (dac.update === 1'b1) n_upd <= n_upd + 1;
    if (dac.abort === 1'b1) n_abt <= n_abt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Send a frame, then check the update and abort pulse counts
  task automatic run(input logic [23:0] w, input int n, input int du, input int da);
    int u0;
    int a0;
    u0 = n_upd;
    a0 = n_abt;
    host.frame(w, n);
    for (int i = 0; i < 40 && (n_upd - u0 != du || n_abt - a0 != da); i++) @(posedge core_clk);
    // Extra cycles catch a spurious second pulse
    repeat (8) @(posedge core_clk);
    chk(32'(n_upd - u0), 32'(du));
    chk(32'(n_abt - a0), 32'(da));
    if (failures != 0) summarize();
  endtask
  // ===========================================
  // Scenarios
  task automatic s_full;
    run({2'h3, 2'h0, CODE_FULL, 2'h3}, 24, 1, 0);
    chk(32'(dac.code), 32'(CODE_FULL));
    chk(32'(dac.rsvd_nonzero), 32'h0);
  endtask
  task automatic s_abort;
    run({2'h0, 2'h0, 18'h15555, 2'h0}, 23, 0, 1);
    chk(32'(dac.code), 32'(CODE_FULL));
  endtask
  task automatic s_zero;
    run({2'h3, 2'h0, CODE_ZERO, 2'h3}, 24, 1, 0);
    chk(32'(dac.code), 32'(CODE_ZERO));
    chk(32'(dac_mid.code), 32'(CODE_ZERO));
  endtask
  task automatic s_long;
    run({2'h0, 2'h3, 18'h2A5C3, 2'h0}, 26, 1, 0);
    chk(32'(dac.code), 32'h0002A5C3);
    chk(32'(dac.rsvd_nonzero), 32'h1);
  endtask
  // Mid-run reset must bring both variants back to their power-on code
  task automatic s_reset;
    reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(32'(dac.code), 32'(CODE_ZERO));
    chk(32'(dac_mid.code), 32'(CODE_MID));
    chk(32'(dac.rsvd_nonzero), 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(32'(dac.code), 32'(CODE_ZERO));
    chk(32'(dac_mid.code), 32'(CODE_MID));
    s_full();
    s_abort();
    s_zero();
    s_long();
    s_reset();
    s_full();
    summarize();
  end
endmodule
